// File: rtl/bec_pkg.sv
// Function
// - missed read parity flag sets on commander read parity error while bit 16, 17 or 18 is already set
// - command/address parity flags for longwords 0,2,1,3 sit at bits 8,9,40,41
// - data parity flags: even longwords at bits 10-13, odd at 42-45
// - status bits clear by writing one; missed read flag clears at power-up
// - commander write parity error sets bit 16, captures address, raises interrupt
// - quadword command mismatch sets bit 17, captures address, raises interrupt
// - no command mismatch check while this device masters the bus
// - invalid map entry sets bit 18 and captures address; bus reset clears it
// - bits 39:19 and 63:46 of bus error status read zero
// - low capture register holds command/address lines 63 to 0
// - high capture register holds command/address lines 127 to 64
// - writes to capture registers complete without error and change nothing
// - target write data parity error sets bit 0, enabled by control bit 63
// - target address parity error sets bit 1, enabled by control bit 62
// - master read data parity error sets bit 2, enabled by control bit 61
// - parity error pin during own cycle sets bit 3, enabled by bit 60
// - system error pin during own master cycle sets bit 4, enabled by bit 59
// - pci status bits clear by write one, reset, or pci reset control bit
// - own master cycle timeout sets bit 5, enabled by control bit 58
// - non-maskable interrupt pin sets bit 6, enabled by control bit 57
package bec_pkg;
  // ==========================================================
  // register map, byte addresses, low word first
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SB_STAT_LO = 8'h00;
  localparam logic [7:0] OFS_SB_STAT_HI = 8'h04;
  localparam logic [7:0] OFS_CAP_LOW_LO = 8'h08;
  localparam logic [7:0] OFS_CAP_LOW_HI = 8'h0C;
  localparam logic [7:0] OFS_CAP_HIGH_LO = 8'h10;
  localparam logic [7:0] OFS_CAP_HIGH_HI = 8'h14;
  localparam logic [7:0] OFS_PCI_STAT_LO = 8'h18;
  localparam logic [7:0] OFS_PCI_STAT_HI = 8'h1C;
  localparam logic [7:0] OFS_CTRL_LO = 8'h20;
  localparam logic [7:0] OFS_CTRL_HI = 8'h24;
  // ==========================================================
  // bus error status fields
  localparam int SB_MISSED_RD_BIT = 7;
  localparam int SB_CA_EVEN_BASE = 8;
  localparam int SB_DATA_EVEN_BASE = 10;
  localparam int SB_CMDR_WR_BIT = 16;
  localparam int SB_SYNC_BIT = 17;
  localparam int SB_MAP_BIT = 18;
  localparam int SB_CA_ODD_BASE = 40;
  localparam int SB_DATA_ODD_BASE = 42;
  localparam logic [63:0] SB_IMPL_MASK = 64'h0000_3F00_0007_3F80;
  localparam logic [63:0] SB_CAPTURE_MASK = 64'h0000_0000_0007_0000;
  localparam logic [63:0] SB_BUSRST_MASK = 64'h0000_0000_0005_0000;
  localparam logic [63:0] SB_IRQ_MASK = 64'h0000_0000_0003_0000;
  localparam logic [63:0] SB_RESET = 64'h0000_0000_0000_0000;
  // ==========================================================
  // pci error status and control fields
  localparam int PCI_W = 7;
  localparam logic [6:0] PCI_RESET = 7'h00;
  localparam int CTRL_PCI_RST_BIT = 0;
  localparam int CTRL_EN_TOP_BIT = 63;
  localparam logic [63:0] CTRL_WR_MASK = 64'hFE00_0000_0000_0001;
  localparam logic [63:0] CTRL_RESET = 64'h0000_0000_0000_0000;
endpackage : bec_pkg

// File: rtl/bec_sticky_bank.sv
`timescale 1ns/1ns
module bec_sticky_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } bec_sticky_t;

  bec_sticky_t state_r;
  bec_sticky_t state_nxt;

  // a set arriving with its clear is kept
  always_comb begin
    state_nxt = state_r;
    state_nxt.flags = (state_r.flags & ~clr) | set;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r.flags <= RESET_VAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign flags = state_r.flags;
endmodule : bec_sticky_bank

// File: rtl/bec_capture.sv
`timescale 1ns/1ns
module bec_capture (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic caValid,
  input wire logic [127:0] cadIn,
  input wire logic capture,
  output logic [63:0] capLow,
  output logic [63:0] capHigh
);
  typedef struct packed {
    logic [127:0] lastCad;
    logic [127:0] held;
  } bec_capture_t;

  bec_capture_t state_r;
  bec_capture_t state_nxt;

  // lastCad follows every command/address transfer; held freezes on capture
  always_comb begin
    state_nxt = state_r;
    if (caValid) begin
      state_nxt.lastCad = cadIn;
    end
    if (capture) begin
      state_nxt.held = caValid ? cadIn : state_r.lastCad;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign capLow = state_r.held[63:0];
  assign capHigh = state_r.held[127:64];
endmodule : bec_capture

// File: rtl/bec_bus_error_capture.sv
`timescale 1ns/1ns
module bec_bus_error_capture (
  input wire logic clock,
  input wire logic rst_n,
  // ==========================================================
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ==========================================================
  // system bus side
  input wire logic sysBusReset,
  input wire logic caValid,
  input wire logic [127:0] cadIn,
  input wire logic [3:0] caParErr,
  input wire logic [7:0] dataParErr,
  input wire logic rdDataParErr,
  input wire logic cmdrWrParErr,
  input wire logic cmdMismatch,
  input wire logic selfMaster,
  input wire logic mapFetchInvalid,
  // ==========================================================
  // pci side
  input wire logic pciWrParErr,
  input wire logic pciAddrParErr,
  input wire logic pciRdParErr,
  input wire logic pciPerrN,
  input wire logic pciParticipant,
  input wire logic pciSerrN,
  input wire logic pciMaster,
  input wire logic pciTimeout,
  input wire logic pciNmi,
  // ==========================================================
  // hardware error interrupt
  output logic hwErrIrq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hwErrIrq;
    logic [63:0] ctrl;
  } bec_main_t;

  bec_main_t state_r;
  bec_main_t state_nxt;

  logic [63:0] sbStatus;
  logic [63:0] sbSet;
  logic [63:0] sbClr;
  logic [6:0] pciStatus;
  logic [6:0] pciSet;
  logic [6:0] pciClr;
  logic [6:0] pciEnable;
  logic [63:0] capLow;
  logic [63:0] capHigh;
  logic capLocked;
  logic captureNow;
  logic setupPhase;
  logic writeDone;
  logic wrSbLo;
  logic wrSbHi;
  logic wrPciLo;
  logic wrCtrlLo;
  logic wrCtrlHi;
  logic [63:0] ctrlWrData;
  logic [63:0] parSet;
  logic [63:0] sbIrqSrc;
  logic [6:0] pciIrqSrc;
  logic irqAny;
  logic [31:0] readWordNow;

  // ==========================================================
  // longword index to status bit: even and odd longwords sit in two ranges
  function automatic logic [5:0] lwBit(
    input int lw,
    input int evenBase,
    input int oddBase
  );
    int pos;
    if ((lw % 2) == 0) begin
      pos = evenBase + (lw / 2);
    end else begin
      pos = oddBase + ((lw - 1) / 2);
    end
    return pos[5:0];
  endfunction : lwBit

  // ==========================================================
  // address decode for mapped words
  function automatic logic isMapped(input logic [7:0] a);
    case (a)
      bec_pkg::OFS_SB_STAT_LO,
      bec_pkg::OFS_SB_STAT_HI,
      bec_pkg::OFS_CAP_LOW_LO,
      bec_pkg::OFS_CAP_LOW_HI,
      bec_pkg::OFS_CAP_HIGH_LO,
      bec_pkg::OFS_CAP_HIGH_HI,
      bec_pkg::OFS_PCI_STAT_LO,
      bec_pkg::OFS_PCI_STAT_HI,
      bec_pkg::OFS_CTRL_LO,
      bec_pkg::OFS_CTRL_HI: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction : isMapped

  // ==========================================================
  // a completed write to the word at a
  function automatic logic wrHit(
    input logic done,
    input logic [7:0] addr,
    input logic [7:0] a
  );
    return done && (addr == a);
  endfunction : wrHit

  // ==========================================================
  // parity source landing on status bit pos, none for other bits
  function automatic logic parSource(
    input int pos,
    input logic [3:0] ca,
    input logic [7:0] data
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (lwBit(i, bec_pkg::SB_CA_EVEN_BASE, bec_pkg::SB_CA_ODD_BASE) == pos[5:0]) begin
        hit = hit | ca[i];
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (lwBit(i, bec_pkg::SB_DATA_EVEN_BASE, bec_pkg::SB_DATA_ODD_BASE) == pos[5:0]) begin
        hit = hit | data[i];
      end
    end
    return hit;
  endfunction : parSource

  // ==========================================================
  // read data of one word; unmapped words read zero
  function automatic logic [31:0] readWord(
    input logic [7:0] a,
    input logic [63:0] sb,
    input logic [63:0] cl,
    input logic [63:0] ch,
    input logic [6:0] pci,
    input logic [63:0] ctrl
  );
    logic [31:0] w;
    case (a)
      bec_pkg::OFS_SB_STAT_LO: w = sb[31:0];
      bec_pkg::OFS_SB_STAT_HI: w = sb[63:32];
      bec_pkg::OFS_CAP_LOW_LO: w = cl[31:0];
      bec_pkg::OFS_CAP_LOW_HI: w = cl[63:32];
      bec_pkg::OFS_CAP_HIGH_LO: w = ch[31:0];
      bec_pkg::OFS_CAP_HIGH_HI: w = ch[63:32];
      bec_pkg::OFS_PCI_STAT_LO: w = {25'h0000000, pci};
      bec_pkg::OFS_PCI_STAT_HI: w = 32'h0000_0000;
      bec_pkg::OFS_CTRL_LO: w = ctrl[31:0];
      bec_pkg::OFS_CTRL_HI: w = ctrl[63:32];
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : readWord

  assign setupPhase = psel && !penable;
  assign writeDone = psel && penable && state_r.pready && pwrite;

  // ==========================================================
  // write strobes and read word
  assign wrSbLo = wrHit(writeDone, paddr, bec_pkg::OFS_SB_STAT_LO);
  assign wrSbHi = wrHit(writeDone, paddr, bec_pkg::OFS_SB_STAT_HI);
  assign wrPciLo = wrHit(writeDone, paddr, bec_pkg::OFS_PCI_STAT_LO);
  assign wrCtrlLo = wrHit(writeDone, paddr, bec_pkg::OFS_CTRL_LO);
  assign wrCtrlHi = wrHit(writeDone, paddr, bec_pkg::OFS_CTRL_HI);
  assign ctrlWrData = {pwdata, pwdata} & bec_pkg::CTRL_WR_MASK;
  assign readWordNow = readWord(paddr, sbStatus, capLow, capHigh, pciStatus, state_r.ctrl);

  // ==========================================================
  // bus error capture ownership
  // any capture-owning flag freezes the captured address
  assign capLocked = |(sbStatus & bec_pkg::SB_CAPTURE_MASK);

  // ==========================================================
  // parity flags: longword n of each transfer kind lands on its own bit
  genvar gb;
  generate
    for (gb = 0; gb < 64; gb++) begin : g_parSet
      assign parSet[gb] = parSource(gb, caParErr, dataParErr);
    end
  endgenerate

  // ==========================================================
  // bus error status set vector
  always_comb begin
    sbSet = parSet;
    // read parity after full status is already taken
    sbSet[bec_pkg::SB_MISSED_RD_BIT] = rdDataParErr && capLocked;
    sbSet[bec_pkg::SB_CMDR_WR_BIT] = cmdrWrParErr;
    // own transfers come from one chip and cannot lose step
    sbSet[bec_pkg::SB_SYNC_BIT] = cmdMismatch && !selfMaster;
    sbSet[bec_pkg::SB_MAP_BIT] = mapFetchInvalid;
    sbSet = sbSet & bec_pkg::SB_IMPL_MASK;
  end

  // first capture-owning error takes the address; later ones leave it
  assign captureNow = !capLocked && |(sbSet & bec_pkg::SB_CAPTURE_MASK);

  // ==========================================================
  // bus error status clear vector
  always_comb begin
    sbClr = '0;
    if (wrSbLo) begin
      sbClr[31:0] = pwdata;
    end
    if (wrSbHi) begin
      sbClr[63:32] = pwdata;
    end
    if (sysBusReset) begin
      sbClr = sbClr | bec_pkg::SB_BUSRST_MASK;
    end
  end

  bec_sticky_bank #(
    .W(64),
    .RESET_VAL(bec_pkg::SB_RESET)
  ) u_sbFlags (
    .clock(clock),
    .rst_n(rst_n),
    .set(sbSet),
    .clr(sbClr),
    .flags(sbStatus)
  );

  bec_capture u_capture (
    .clock(clock),
    .rst_n(rst_n),
    .caValid(caValid),
    .cadIn(cadIn),
    .capture(captureNow),
    .capLow(capLow),
    .capHigh(capHigh)
  );

  // ==========================================================
  // pci error status
  always_comb begin
    pciSet = '0;
    pciSet[0] = pciWrParErr;
    pciSet[1] = pciAddrParErr;
    pciSet[2] = pciRdParErr;
    // parity error pin is driven by other agents
    pciSet[3] = !pciPerrN && pciParticipant;
    pciSet[4] = !pciSerrN && pciMaster;
    pciSet[5] = pciTimeout && pciMaster;
    pciSet[6] = pciNmi;
  end

  always_comb begin
    pciClr = '0;
    if (wrPciLo) begin
      pciClr = pwdata[6:0];
    end
    if (state_r.ctrl[bec_pkg::CTRL_PCI_RST_BIT]) begin
      pciClr = '1;
    end
  end

  bec_sticky_bank #(
    .W(bec_pkg::PCI_W),
    .RESET_VAL(bec_pkg::PCI_RESET)
  ) u_pciFlags (
    .clock(clock),
    .rst_n(rst_n),
    .set(pciSet),
    .clr(pciClr),
    .flags(pciStatus)
  );

  // enable for pci bit k is control bit 63-k
  genvar g;
  generate
    for (g = 0; g < bec_pkg::PCI_W; g++) begin : g_pciEn
      assign pciEnable[g] = state_r.ctrl[bec_pkg::CTRL_EN_TOP_BIT - g];
    end
  endgenerate

  // ==========================================================
  // interrupt sources: bus flags 16 and 17 always report, pci flags when enabled
  assign sbIrqSrc = sbStatus & bec_pkg::SB_IRQ_MASK;
  assign pciIrqSrc = pciStatus & pciEnable;
  assign irqAny = (|sbIrqSrc) || (|pciIrqSrc);

  // ==========================================================
  // next state: bus answer, control register, interrupt
  always_comb begin
    state_nxt = state_r;
    // one access cycle per transfer, no wait states
    state_nxt.pready = setupPhase;
    state_nxt.pslverr = setupPhase && !isMapped(paddr);
    if (setupPhase) begin
      state_nxt.prdata = readWordNow;
    end else begin
      state_nxt.prdata = 32'h0000_0000;
    end
    // capture words accept writes and ignore them
    if (wrCtrlLo) begin
      state_nxt.ctrl[31:0] = ctrlWrData[31:0];
    end
    if (wrCtrlHi) begin
      state_nxt.ctrl[63:32] = ctrlWrData[63:32];
    end
    if (sysBusReset) begin
      state_nxt.ctrl = bec_pkg::CTRL_RESET;
    end
    // stays high while any enabled flag remains set
    state_nxt.hwErrIrq = irqAny;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r.prdata <= 32'h0000_0000;
      state_r.pready <= 1'b0;
      state_r.pslverr <= 1'b0;
      state_r.hwErrIrq <= 1'b0;
      state_r.ctrl <= bec_pkg::CTRL_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign hwErrIrq = state_r.hwErrIrq;
endmodule : bec_bus_error_capture

// File: bench/bec_pci_agent.sv
`timescale 1ns/1ns
module bec_pci_agent (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic perrReq,
  input wire logic serrReq,
  output logic pciPerrN,
  output logic pciSerrN
);
  // ==========================================================
  // error reports, released lines sit at their pulled-up level
  always_ff @(posedge clock) begin
    pciPerrN <= !(rst_n && perrReq);
    pciSerrN <= !(rst_n && serrReq);
  end
endmodule : bec_pci_agent

// File: bench/bec_bus_error_capture_chk.sv
`timescale 1ns/1ns
module bec_bus_error_capture_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmdrWrParErr,
  input wire logic cmdMismatch,
  input wire logic selfMaster,
  input wire logic hwErrIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire setup = psel && !penable;
  // ==========================================================
  // register bus
  a_ready_after_setup: assert property (setup |=> pready) else $error("ready missing");
  a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_unmapped_error: assert property (setup && paddr > bec_pkg::OFS_CTRL_HI |=> pslverr)
    else $error("unmapped accepted");
  a_cap_write_ok: assert property (setup && pwrite && paddr[1:0] == 2'h0 &&
    paddr inside {[8'h08:8'h14]} |=> !pslverr)
    else $error("capture write refused");
  a_status_lo_zero: assert property (setup && paddr == bec_pkg::OFS_SB_STAT_LO |=> prdata[31:19] == '0)
    else $error("status low reserved set");
  a_status_hi_zero: assert property (setup && paddr == bec_pkg::OFS_SB_STAT_HI |=>
    prdata[31:14] == '0 && prdata[7:0] == '0) else $error("status high reserved set");
  // ==========================================================
  // interrupt
  a_irq_cmdr_write: assert property (cmdrWrParErr |-> ##2 hwErrIrq) else $error("no irq");
  a_irq_bus_sync: assert property (cmdMismatch && !selfMaster |-> ##2 hwErrIrq)
    else $error("no sync irq");
endmodule : bec_bus_error_capture_chk

bind bec_bus_error_capture bec_bus_error_capture_chk i_bec_bus_error_capture_chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmdrWrParErr(cmdrWrParErr), .cmdMismatch(cmdMismatch), .selfMaster(selfMaster),
  .hwErrIrq(hwErrIrq));

// File: bench/bec_bus_error_capture_bench.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module bec_bus_error_capture_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sysBusReset = 1'b0;
  logic selfMaster = 1'b0, part = 1'b0, mst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, hwErrIrq, pciPerrN, pciSerrN;
  logic [127:0] cadIn = 128'h0;
  logic [23:0] ev = 24'h0;
  logic [63:0] v;
  int failures = 0;
  int totalChecks = 0;
  bec_bus_error_capture i_bec_bus_error_capture (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysBusReset(sysBusReset), .caValid(ev[23]), .cadIn(cadIn), .caParErr(ev[14:11]),
    .dataParErr(ev[22:15]), .rdDataParErr(ev[3]), .cmdrWrParErr(ev[0]),
    .cmdMismatch(ev[1]), .selfMaster(selfMaster), .mapFetchInvalid(ev[2]),
    .pciWrParErr(ev[4]), .pciAddrParErr(ev[5]), .pciRdParErr(ev[6]), .pciPerrN(pciPerrN),
    .pciParticipant(part), .pciSerrN(pciSerrN), .pciMaster(mst), .pciTimeout(ev[9]),
    .pciNmi(ev[10]), .hwErrIrq(hwErrIrq));
  bec_pci_agent i_bec_pci_agent (.clock(clock), .rst_n(rst_n), .perrReq(ev[7]),
    .serrReq(ev[8]), .pciPerrN(pciPerrN), .pciSerrN(pciSerrN));
  // ==========================================================
  // bus and event drivers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      conclude();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd64(input logic [7:0] a, output logic [63:0] q);
    logic err;
    apb(1'b0, a, 32'h0, q[31:0], err);
    apb(1'b0, a + 8'h04, 32'h0, q[63:32], err);
  endtask : rd64
  task automatic wr64(input logic [7:0] a, input logic [63:0] d);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, d[31:0], q, err);
    apb(1'b1, a + 8'h04, d[63:32], q, err);
  endtask : wr64
  task automatic pulse(input logic [23:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 24'h0;
    repeat (3) @(posedge clock);
  endtask : pulse
  // ==========================================================
  // scenarios
  task automatic sc_reset();
    logic [31:0] q;
    logic err;
    for (int a = 0; a < 40; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, q, err);
      `CHK("reset value", 32'h0, q)
    end
    apb(1'b1, 8'h28, 32'hFFFFFFFF, q, err);
    `CHK("unmapped", 1'b1, err)
  endtask : sc_reset
  task automatic sc_cmdr();
    cadIn <= 128'h0123456789ABCDEF_FEDCBA9876543210;
    pulse(24'h000008);
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("missed alone", 64'h0, v)
    pulse(24'h800001);
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("cmdr write", 64'h10000, v)
    `CHK("irq cmdr", 1'b1, hwErrIrq)
    wr64(bec_pkg::OFS_CAP_LOW_LO, 64'hFFFFFFFFFFFFFFFF);
    rd64(bec_pkg::OFS_CAP_LOW_LO, v);
    `CHK("cap low", 64'hFEDCBA9876543210, v)
    rd64(bec_pkg::OFS_CAP_HIGH_LO, v);
    `CHK("cap high", 64'h0123456789ABCDEF, v)
    pulse(24'h000008);
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("missed", 64'h10080, v)
    wr64(bec_pkg::OFS_SB_STAT_LO, 64'h10080);
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("cleared", 64'h0, v)
    `CHK("irq off", 1'b0, hwErrIrq)
  endtask : sc_cmdr
  task automatic sc_sync_map();
    selfMaster <= 1'b1;
    pulse(24'h000002);
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("own master", 64'h0, v)
    selfMaster <= 1'b0;
    pulse(24'h000002);
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("sync", 64'h20000, v)
    `CHK("irq sync", 1'b1, hwErrIrq)
    wr64(bec_pkg::OFS_SB_STAT_LO, 64'h20000);
    pulse(24'h000004);
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("map", 64'h40000, v)
    @(posedge clock);
    sysBusReset <= 1'b1;
    @(posedge clock);
    sysBusReset <= 1'b0;
    rd64(bec_pkg::OFS_SB_STAT_LO, v);
    `CHK("bus reset", 64'h0, v)
  endtask : sc_sync_map
  task automatic sc_parity();
    int b;
    for (int k = 0; k < 12; k++) begin
      b = (k < 4) ? ((k % 2) ? 40 : 8) + k / 2 : (((k - 4) % 2) ? 42 : 10) + (k - 4) / 2;
      pulse(24'h000800 << k);
      rd64(bec_pkg::OFS_SB_STAT_LO, v);
      `CHK("parity flag", 64'h1 << b, v)
      wr64(bec_pkg::OFS_SB_STAT_LO, v);
    end
  endtask : sc_parity
  task automatic sc_pci();
    part <= 1'b1;
    mst <= 1'b1;
    wr64(bec_pkg::OFS_CTRL_LO, 64'hFE00000000000000);
    for (int b = 0; b < 7; b++) begin
      pulse(24'h000010 << b);
      rd64(bec_pkg::OFS_PCI_STAT_LO, v);
      `CHK("pci flag", 64'h1 << b, v)
      `CHK("pci irq", 1'b1, hwErrIrq)
      wr64(bec_pkg::OFS_PCI_STAT_LO, 64'h1 << b);
      `CHK("pci irq off", 1'b0, hwErrIrq)
    end
    wr64(bec_pkg::OFS_CTRL_LO, 64'h0);
    part <= 1'b0;
    pulse(24'h000090);
    rd64(bec_pkg::OFS_PCI_STAT_LO, v);
    `CHK("masked", 64'h1, v)
    `CHK("masked irq", 1'b0, hwErrIrq)
    wr64(bec_pkg::OFS_CTRL_LO, 64'h1);
    wr64(bec_pkg::OFS_CTRL_LO, 64'h0);
    rd64(bec_pkg::OFS_PCI_STAT_LO, v);
    `CHK("pci reset", 64'h0, v)
  endtask : sc_pci
  // ==========================================================
  // run control
  task automatic conclude();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial forever #10 clock = ~clock;
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    sc_reset();
    sc_cmdr();
    sc_sync_map();
    sc_parity();
    sc_pci();
    conclude();
  end
endmodule : bec_bus_error_capture_bench
